/* hw/cmq_top.sv */
// cmq_top: configuration interpreter for resource sizing and the inbound message queue
//
// How it works
// - all-ones movable address in front-end modes selects the default location.
// - reply returns the movable area address actually in use.
// - process count: all-ones keeps, reset 12, accepts 1 to 128 in front-end modes.
// - user mailbox count: all-ones keeps, reset 16, accepts 1 to 128 in front-end modes.
// - multicast slot count: all-ones keeps, reset 8, accepts 0 to 252 in front-end modes.
// - host count: all-ones keeps, starts at 0, modes 0 and 1 allow 1 only.
// - network boot allows 0 hosts; then queues are absent and queue fields ignored.
// - segmented queue base has segment high, offset low, offset zero.
// - absolute queue base is 24 bits, top byte and low nibble zero.
// - queue addresses are 16-bit offsets added to the queue base.
// - notify type 0 polls, 1 port write, 2 memory write, 3 level line.
// - level line stays high until the host writes port A.
// - type 3 sets a status bit readable at port B with the line.
// - port and memory types write the notify byte at each signal.
// - port type uses the low word; memory type follows the address mode.
// - host count and queue fields come back unchanged in the reply.
// - operation mode 0 link, 1 host download, 2 net download, others reserved.
// - address mode bit 0 selects segmented, 1 absolute addressing.
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module cmq_top
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        board_evt,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             note_wr_q,
  output logic             note_io_q,
  output logic      [23:0] note_addr_q,
  output logic      [7:0]  note_data_q,
  output logic             irq_q,
  output logic             queues_on_q
);
  logic        rst_s1_q;
  logic        rst_n_q;
  logic        awready_q;
  logic        aw_got_q;
  logic [7:0]  awaddr_q;
  logic        wready_q;
  logic        w_got_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        wr_en;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_data;
  logic        ctrl_wr;
  logic        apply;
  logic        sw_evt;
  logic [31:0] req_mode_q;
  logic [31:0] req_mov_q;
  logic [31:0] req_cnt_q;
  logic [31:0] req_qbase_q;
  logic [31:0] req_qnote_q;
  logic [31:0] req_qiaddr_q;
  logic [15:0] qoff_q;
  logic [1:0]  op_q;
  logic        amode_q;
  logic [15:0] mov_q;
  logic [31:0] cnt_q;
  logic [31:0] qbase_q;
  logic [15:0] qhdr_q;
  logic [7:0]  ntype_q;
  logic [7:0]  nval_q;
  logic [31:0] naddr_q;
  logic [7:0]  err_q;
  logic        done_q;
  logic        irq_stat;
  logic [7:0]  chk_err;
  logic        chk_amode;
  logic [15:0] chk_mov;
  logic [31:0] chk_cnt;
  logic [23:0] qcalc;

  cmq_cfg_if cfg ();

  // nrst is asynchronous to clk; only its release is synchronised
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // write address and data are taken independently; one write under way at a time
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b0;
      awaddr_q  <= 8'h00;
    end
    else if (s_axi_awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      awready_q <= 1'b1;
      aw_got_q  <= 1'b0;
    end
    else if (!aw_got_q)
      awready_q <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end
    else if (s_axi_wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      wready_q <= 1'b1;
      w_got_q  <= 1'b0;
    end
    else if (!w_got_q)
      wready_q <= 1'b1;
  end

  assign wr_en = aw_got_q && w_got_q && !bvalid_q;

  always_comb
  begin
    if ((awaddr_q == cmq_pkg::A_CTRL) || (awaddr_q == cmq_pkg::A_REQ_MODE)
        || (awaddr_q == cmq_pkg::A_REQ_MOV) || (awaddr_q == cmq_pkg::A_REQ_CNT)
        || (awaddr_q == cmq_pkg::A_REQ_QBASE) || (awaddr_q == cmq_pkg::A_REQ_QNOTE)
        || (awaddr_q == cmq_pkg::A_REQ_QIADDR) || (awaddr_q == cmq_pkg::A_PORT_A)
        || (awaddr_q == cmq_pkg::A_QCALC))
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= cmq_pkg::RESP_OKAY;
    end
    else if (wr_en)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? cmq_pkg::RESP_OKAY : cmq_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        merge[8*i +: 8] = nw[8*i +: 8];
  endfunction

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      req_mode_q   <= cmq_pkg::REQ_MODE_RST;
      req_mov_q    <= cmq_pkg::REQ_ALL_ONES;
      req_cnt_q    <= cmq_pkg::REQ_ALL_ONES;
      req_qbase_q  <= cmq_pkg::REQ_ZERO;
      req_qnote_q  <= cmq_pkg::REQ_ZERO;
      req_qiaddr_q <= cmq_pkg::REQ_ZERO;
      qoff_q       <= 16'h0000;
    end
    else if (wr_en)
    begin
      if (awaddr_q == cmq_pkg::A_REQ_MODE)
        req_mode_q <= merge(req_mode_q, wdata_q, wstrb_q);
      else if (awaddr_q == cmq_pkg::A_REQ_MOV)
        req_mov_q <= merge(req_mov_q, wdata_q, wstrb_q);
      else if (awaddr_q == cmq_pkg::A_REQ_CNT)
        req_cnt_q <= merge(req_cnt_q, wdata_q, wstrb_q);
      else if (awaddr_q == cmq_pkg::A_REQ_QBASE)
        req_qbase_q <= merge(req_qbase_q, wdata_q, wstrb_q);
      else if (awaddr_q == cmq_pkg::A_REQ_QNOTE)
        req_qnote_q <= merge(req_qnote_q, wdata_q, wstrb_q);
      else if (awaddr_q == cmq_pkg::A_REQ_QIADDR)
        req_qiaddr_q <= merge(req_qiaddr_q, wdata_q, wstrb_q);
      else if (awaddr_q == cmq_pkg::A_QCALC)
        qoff_q <= 16'(merge({16'h0000, qoff_q}, wdata_q, wstrb_q));
    end
  end

  assign ctrl_wr = wr_en && (awaddr_q == cmq_pkg::A_CTRL) && wstrb_q[0];
  assign apply   = ctrl_wr && wdata_q[cmq_pkg::CTRL_APPLY_BIT];
  assign sw_evt  = ctrl_wr && wdata_q[cmq_pkg::CTRL_EVT_BIT];

  cmq_check u_check
  (
    .req_op    (req_mode_q[7:0]),
    .req_mode  (req_mode_q),
    .req_mov   (req_mov_q),
    .req_cnt   (req_cnt_q),
    .req_qbase (req_qbase_q),
    .req_ntype (req_qnote_q[23:16]),
    .cur_amode (amode_q),
    .cur_cnt   (cnt_q),
    .cur_mov   (mov_q),
    .err       (chk_err),
    .amode     (chk_amode),
    .mov       (chk_mov),
    .cnt       (chk_cnt)
  );

  // a rejected request leaves every applied setting untouched
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      op_q    <= 2'b00;
      amode_q <= 1'b0;
      mov_q   <= cmq_pkg::MOV_DEF;
      cnt_q   <= {cmq_pkg::HOSTS_RST, cmq_pkg::MCAST_RST, cmq_pkg::MBOX_RST, cmq_pkg::PROC_RST};
      qbase_q <= cmq_pkg::REQ_ZERO;
      qhdr_q  <= 16'h0000;
      ntype_q <= 8'h00;
      nval_q  <= 8'h00;
      naddr_q <= cmq_pkg::REQ_ZERO;
      err_q   <= cmq_pkg::ERR_NONE;
      done_q  <= 1'b0;
    end
    else if (apply)
    begin
      err_q  <= chk_err;
      done_q <= 1'b1;
      if (chk_err == cmq_pkg::ERR_NONE)
      begin
        op_q    <= req_mode_q[1:0];
        amode_q <= chk_amode;
        mov_q   <= chk_mov;
        cnt_q   <= chk_cnt;
        if (chk_cnt[31:24] == 8'h01)
        begin
          qbase_q <= req_qbase_q;
          qhdr_q  <= req_qnote_q[15:0];
          ntype_q <= req_qnote_q[23:16];
          nval_q  <= req_qnote_q[31:24];
          naddr_q <= req_qiaddr_q;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      queues_on_q <= 1'b0;
    else if (apply && (chk_err == cmq_pkg::ERR_NONE))
      queues_on_q <= (chk_cnt[31:24] == 8'h01);
  end

  assign cfg.qen   = queues_on_q;
  assign cfg.amode = amode_q;
  assign cfg.ntype = cmq_pkg::cmq_ntype_t'(ntype_q[1:0]);
  assign cfg.nval  = nval_q;
  assign cfg.naddr = naddr_q;
  // board_evt comes from logic on clk and needs no synchroniser
  assign cfg.evt   = sw_evt || board_evt;
  assign cfg.clr   = wr_en && (awaddr_q == cmq_pkg::A_PORT_A);

  cmq_notify u_notify
  (
    .clk         (clk),
    .rst_n       (rst_n_q),
    .cfg         (cfg),
    .note_wr_q   (note_wr_q),
    .note_io_q   (note_io_q),
    .note_addr_q (note_addr_q),
    .note_data_q (note_data_q),
    .irq_q       (irq_q),
    .irq_stat_q  (irq_stat)
  );

  assign qcalc = cmq_pkg::cmq_host_addr(amode_q, qbase_q) + {8'h00, qoff_q};

  always_comb
  begin
    rd_hit = 1'b1;
    if (s_axi_araddr == cmq_pkg::A_CTRL)
      rd_data = 32'h0000_0000;
    else if (s_axi_araddr == cmq_pkg::A_REQ_MODE)
      rd_data = req_mode_q;
    else if (s_axi_araddr == cmq_pkg::A_REQ_MOV)
      rd_data = req_mov_q;
    else if (s_axi_araddr == cmq_pkg::A_REQ_CNT)
      rd_data = req_cnt_q;
    else if (s_axi_araddr == cmq_pkg::A_REQ_QBASE)
      rd_data = qbase_q;
    else if (s_axi_araddr == cmq_pkg::A_REQ_QNOTE)
      rd_data = {nval_q, ntype_q, qhdr_q};
    else if (s_axi_araddr == cmq_pkg::A_REQ_QIADDR)
      rd_data = naddr_q;
    else if (s_axi_araddr == cmq_pkg::A_RPL_MOV)
      rd_data = {16'h0000, mov_q};
    else if (s_axi_araddr == cmq_pkg::A_RPL_CNT)
      rd_data = cnt_q;
    else if (s_axi_araddr == cmq_pkg::A_RPL_STAT)
      rd_data = {19'h0_0000, queues_on_q, amode_q, op_q, done_q, err_q};
    else if (s_axi_araddr == cmq_pkg::A_PORT_A)
      rd_data = 32'h0000_0000;
    else if (s_axi_araddr == cmq_pkg::A_PORT_B)
      rd_data = {31'h0000_0000, irq_stat};
    else if (s_axi_araddr == cmq_pkg::A_QCALC)
      rd_data = {8'h00, qcalc};
    else
    begin
      rd_hit  = 1'b0;
      rd_data = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= cmq_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_hit ? cmq_pkg::RESP_OKAY : cmq_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
    else if (!rvalid_q)
      arready_q <= 1'b1;
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule
`default_nettype wire

/* hw/cmq_pkg.sv */
// cmq_pkg: register map, field layout, defaults and codes of the configuration interpreter
package cmq_pkg;

  localparam logic [7:0] A_CTRL       = 8'h00;
  localparam logic [7:0] A_REQ_MODE   = 8'h04;
  localparam logic [7:0] A_REQ_MOV    = 8'h08;
  localparam logic [7:0] A_REQ_CNT    = 8'h0C;
  localparam logic [7:0] A_REQ_QBASE  = 8'h10;
  localparam logic [7:0] A_REQ_QNOTE  = 8'h14;
  localparam logic [7:0] A_REQ_QIADDR = 8'h18;
  localparam logic [7:0] A_RPL_MOV    = 8'h20;
  localparam logic [7:0] A_RPL_CNT    = 8'h24;
  localparam logic [7:0] A_RPL_STAT   = 8'h28;
  localparam logic [7:0] A_PORT_A     = 8'h2C;
  localparam logic [7:0] A_PORT_B     = 8'h30;
  localparam logic [7:0] A_QCALC      = 8'h34;

  localparam int CTRL_APPLY_BIT = 0;
  localparam int CTRL_EVT_BIT   = 1;
  localparam int AM_SET_BIT     = 8;
  localparam int AM_MODE_BIT    = 9;

  localparam logic [31:0] REQ_MODE_RST = 32'h0000_0000;
  localparam logic [31:0] REQ_ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] REQ_ZERO     = 32'h0000_0000;

  localparam logic [7:0]  KEEP8      = 8'hFF;
  localparam logic [7:0]  PROC_RST   = 8'h0C;
  localparam logic [7:0]  MBOX_RST   = 8'h10;
  localparam logic [7:0]  MCAST_RST  = 8'h08;
  localparam logic [7:0]  HOSTS_RST  = 8'h00;
  localparam logic [7:0]  CNT_MIN    = 8'h01;
  localparam logic [7:0]  CNT_MAX    = 8'h80;
  localparam logic [7:0]  MCAST_MAX  = 8'hFC;
  localparam logic [15:0] MOV_DEF    = 16'h0400;
  localparam logic [15:0] MOV_SIZE   = 16'h0100;
  localparam logic [15:0] WIN_LO_MIN = 16'h0200;
  localparam logic [15:0] WIN_LO_MAX = 16'h03FF;
  localparam logic [15:0] WIN_HI_MIN = 16'h1000;
  localparam logic [15:0] WIN_HI_MAX = 16'hFFFF;

  localparam logic [7:0] ERR_NONE  = 8'h00;
  localparam logic [7:0] ERR_MODE  = 8'hA0;
  localparam logic [7:0] ERR_MOV   = 8'hA1;
  localparam logic [7:0] ERR_CNT   = 8'hA2;
  localparam logic [7:0] ERR_HOSTS = 8'hA3;
  localparam logic [7:0] ERR_QBASE = 8'hA4;
  localparam logic [7:0] ERR_NTYPE = 8'hA5;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {OP_LINK, OP_FE_HOST, OP_FE_NET, OP_RSV} cmq_mode_t;
  typedef enum logic [1:0] {NT_POLL, NT_IO, NT_MEM, NT_LEVEL} cmq_ntype_t;

  // segmented: segment*16 + offset; absolute: low 24 bits
  function automatic logic [23:0] cmq_host_addr(input logic am, input logic [31:0] lw);
    if (am)
      cmq_host_addr = lw[23:0];
    else
      cmq_host_addr = {4'h0, lw[31:16], 4'h0} + {8'h00, lw[15:0]};
  endfunction

endpackage

/* hw/cmq_cfg_if.sv */
// cmq_cfg_if: applied notification settings and events passed to the notifier
`timescale 1ns/100ps
`default_nettype none
interface cmq_cfg_if;
  logic                   qen;
  logic                   amode;
  cmq_pkg::cmq_ntype_t    ntype;
  logic [7:0]             nval;
  logic [31:0]            naddr;
  logic                   evt;
  logic                   clr;
  modport src (output qen, output amode, output ntype, output nval, output naddr,
               output evt, output clr);
  modport dst (input qen, input amode, input ntype, input nval, input naddr,
               input evt, input clr);
endinterface
`default_nettype wire

/* hw/cmq_check.sv */
// cmq_check: validation of a configuration request against the current settings
`timescale 1ns/100ps
`default_nettype none
module cmq_check
(
  input  wire logic [7:0]  req_op,
  input  wire logic [31:0] req_mode,
  input  wire logic [31:0] req_mov,
  input  wire logic [31:0] req_cnt,
  input  wire logic [31:0] req_qbase,
  input  wire logic [7:0]  req_ntype,
  input  wire logic        cur_amode,
  input  wire logic [31:0] cur_cnt,
  input  wire logic [15:0] cur_mov,
  output logic      [7:0]  err,
  output logic             amode,
  output logic      [15:0] mov,
  output logic      [31:0] cnt
);
  logic [16:0] mov_end;
  logic        link;
  logic        net;
  logic        qen;
  logic        win_ok;

  function automatic logic cnt_bad(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi, input logic lk);
    cnt_bad = (v != cmq_pkg::KEEP8) && (lk || (v < lo) || (v > hi));
  endfunction

  always_comb
  begin
    link    = (req_op == 8'h00);
    net     = (req_op == 8'h02);
    amode   = req_mode[cmq_pkg::AM_SET_BIT] ? req_mode[cmq_pkg::AM_MODE_BIT] : cur_amode;
    mov_end = {1'b0, req_mov[15:0]} + {1'b0, cmq_pkg::MOV_SIZE} - 17'h0_0001;
    win_ok  = ((req_mov[15:0] >= cmq_pkg::WIN_LO_MIN) && (mov_end <= {1'b0, cmq_pkg::WIN_LO_MAX}))
           || ((req_mov[15:0] >= cmq_pkg::WIN_HI_MIN) && (mov_end <= {1'b0, cmq_pkg::WIN_HI_MAX}));
    for (int i = 0; i < 4; i++)
      cnt[8*i +: 8] = (req_cnt[8*i +: 8] == cmq_pkg::KEEP8) ? cur_cnt[8*i +: 8]
                                                            : req_cnt[8*i +: 8];
    qen = (cnt[31:24] == 8'h01);
    if (req_mov == cmq_pkg::REQ_ALL_ONES)
      mov = cmq_pkg::MOV_DEF;
    else
      mov = req_mov[15:0];
    if (req_op > 8'h02)
      err = cmq_pkg::ERR_MODE;
    else if ((req_mov != cmq_pkg::REQ_ALL_ONES) && (link || (req_mov[31:16] != 16'h0000) || !win_ok))
      err = cmq_pkg::ERR_MOV;
    else if (cnt_bad(req_cnt[7:0], cmq_pkg::CNT_MIN, cmq_pkg::CNT_MAX, link)
          || cnt_bad(req_cnt[15:8], cmq_pkg::CNT_MIN, cmq_pkg::CNT_MAX, link)
          || cnt_bad(req_cnt[23:16], 8'h00, cmq_pkg::MCAST_MAX, link))
      err = cmq_pkg::ERR_CNT;
    else if (net ? (cnt[31:24] > 8'h01) : (cnt[31:24] != 8'h01))
      err = cmq_pkg::ERR_HOSTS;
    else if (qen && (amode ? ((req_qbase[31:24] != 8'h00) || (req_qbase[3:0] != 4'h0))
                           : (req_qbase[15:0] != 16'h0000)))
      err = cmq_pkg::ERR_QBASE;
    else if (qen && (req_ntype > 8'h03))
      err = cmq_pkg::ERR_NTYPE;
    else
      err = cmq_pkg::ERR_NONE;
  end
endmodule
`default_nettype wire

/* hw/cmq_notify.sv */
// cmq_notify: signals the host about the inbound queue by port write, memory write or level line
`timescale 1ns/100ps
`default_nettype none
module cmq_notify
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  cmq_cfg_if.dst           cfg,
  output logic             note_wr_q,
  output logic             note_io_q,
  output logic      [23:0] note_addr_q,
  output logic      [7:0]  note_data_q,
  output logic             irq_q,
  output logic             irq_stat_q
);
  logic fire;

  assign fire = cfg.evt && cfg.qen;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      note_wr_q   <= 1'b0;
      note_io_q   <= 1'b0;
      note_addr_q <= 24'h00_0000;
      note_data_q <= 8'h00;
    end
    else
    begin
      note_wr_q <= 1'b0;
      if (fire)
      begin
        case (cfg.ntype)
          cmq_pkg::NT_IO:
          begin
            note_wr_q   <= 1'b1;
            note_io_q   <= 1'b1;
            note_addr_q <= {8'h00, cfg.naddr[15:0]};
            note_data_q <= cfg.nval;
          end
          cmq_pkg::NT_MEM:
          begin
            note_wr_q   <= 1'b1;
            note_io_q   <= 1'b0;
            note_addr_q <= cmq_pkg::cmq_host_addr(cfg.amode, cfg.naddr);
            note_data_q <= cfg.nval;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // the raise wins over a port write in the same cycle so no event is lost
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q      <= 1'b0;
      irq_stat_q <= 1'b0;
    end
    else if (fire && (cfg.ntype == cmq_pkg::NT_LEVEL))
    begin
      irq_q      <= 1'b1;
      irq_stat_q <= 1'b1;
    end
    else if (cfg.clr)
    begin
      irq_q      <= 1'b0;
      irq_stat_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* dv/cmq_top_assertions.sv */
// cmq_top_assertions: port checks of the configuration interpreter
`timescale 1ns/100ps
`default_nettype none
module cmq_top_assertions
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       board_evt,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       note_wr_q,
  input wire logic       irq_q,
  input wire logic       queues_on_q
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_note_needs_q: assert property (note_wr_q |-> $past(queues_on_q))
    else $error("note without queues");
  a_note_cause: assert property (note_wr_q |-> $past(board_evt) || s_axi_bvalid
    || $past(s_axi_bvalid)) else $error("note without cause");
  a_irq_holds: assert property (irq_q |=> irq_q || $rose(s_axi_bvalid))
    else $error("irq dropped early");
  a_irq_needs_q: assert property ($rose(irq_q) |-> $past(queues_on_q))
    else $error("irq without queues");
  a_one_kind: assert property (!(note_wr_q && $rose(irq_q)))
    else $error("two notify kinds");
  a_q_on_apply: assert property ($changed(queues_on_q) |-> s_axi_bvalid)
    else $error("queues changed off apply");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write response");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  c_note: cover property (note_wr_q);
  c_irq: cover property (irq_q);
  c_evt_on: cover property (queues_on_q && board_evt);
endmodule
bind cmq_top cmq_top_assertions u_chk (.*);
`default_nettype wire

/* dv/cmq_host_model.sv */
// cmq_host_model: host side of the register bus, one write and one read at a time
`timescale 1ns/100ps
`default_nettype none
module cmq_host_model
(
  input  wire logic        clk,
  output logic      [7:0]  s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [7:0]  s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = {10'h000, 4'hF};
  end

  // released payload shows the inverse so a stale value is never mistaken for data
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit got;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    got = 1'b0;
    while (!got)
    begin
      @(posedge clk);
      if (s_axi_awready)
        {s_axi_awaddr, s_axi_awvalid} <= {~a, 1'b0};
      if (s_axi_wready)
        {s_axi_wdata, s_axi_wvalid} <= {~d, 1'b0};
      if (s_axi_bvalid)
      begin
        {r, got} = {s_axi_bresp, 1'b1};
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got;
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    got = 1'b0;
    while (!got)
    begin
      @(posedge clk);
      if (s_axi_arready)
        {s_axi_araddr, s_axi_arvalid} <= {~a, 1'b0};
      if (s_axi_rvalid)
      begin
        {d, r, got} = {s_axi_rdata, s_axi_rresp, 1'b1};
        s_axi_rready <= 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

/* dv/cmq_top_tb_top.sv */
// cmq_top_tb_top: self-checking bench for the configuration interpreter
`timescale 1ns/100ps
`default_nettype none
module cmq_top_tb_top;
  logic        clk, nrst, board_evt, note_wr_q, note_io_q, irq_q, queues_on_q;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, note_data_q, nv, e;
  logic [15:0] sg, ia;
  logic [23:0] note_addr_q;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, m, mv, c, q, n, cnt;
  int          fails, samples_checked, t;

  cmq_top uut (.*);
  cmq_host_model host (.*);

  task automatic chk(input string what, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    host.rd(a, rv, rr);
    chk(what, rv, exp);
  endtask

  // request words sit at consecutive offsets from the mode word on
  task automatic apply(input logic [31:0] w [5]);
    for (int i = 0; i < 5; i++)
      host.wr(8'(4 * i + 4), w[i], rr);
    host.wr(cmq_pkg::A_CTRL, 32'h0000_0001, rr);
    host.rd(cmq_pkg::A_RPL_STAT, rv, rr);
  endtask

  task automatic pulse;
    @(posedge clk);
    board_evt <= 1'b1;
    @(posedge clk);
    board_evt <= 1'b0;
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  initial
  begin
    {nrst, board_evt, fails, samples_checked} = '0;
    t = $urandom(32'h0000_8ce5);
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(cmq_pkg::A_RPL_CNT, 32'h0008_100C, "reset counts");
    cnt = {8'h01, 8'($urandom % 253), 8'(1 + $urandom % 128), 8'(1 + $urandom % 128)};
    {sg, nv, ia} = {$urandom, $urandom};
    host.wr(cmq_pkg::A_REQ_QIADDR, {16'h0000, ia}, rr);
    for (t = 1; t < 5; t++)
    begin
      mv = (t == 2) ? 32'h0000_0200 : cmq_pkg::REQ_ALL_ONES;
      n = {nv, 6'h00, t[1:0], 16'h0010};
      apply('{32'h0000_0001, mv, (t == 1) ? cnt : cmq_pkg::REQ_ALL_ONES, {sg, 16'h0000}, n});
      chk("status", rv[7:0], cmq_pkg::ERR_NONE);
      rdchk(cmq_pkg::A_RPL_CNT, cnt, "counts");
      rdchk(cmq_pkg::A_RPL_MOV, (t == 2) ? mv : {16'h0000, cmq_pkg::MOV_DEF}, "movable");
      rdchk(cmq_pkg::A_REQ_QNOTE, n, "note reply");
      pulse();
      chk("notify", {note_wr_q, irq_q}, {t < 3, t == 3});
      if (t < 3)
        chk("note data", {note_io_q, note_data_q, note_addr_q}, {t == 1, nv, 8'h00, ia});
      if (t == 3)
      begin
        rdchk(cmq_pkg::A_PORT_B, 32'h0000_0001, "irq status");
        host.wr(cmq_pkg::A_PORT_A, 32'h0000_0000, rr);
        chk("irq cleared", irq_q, 1'b0);
      end
    end
    host.wr(cmq_pkg::A_QCALC, 32'h0000_0010, rr);
    rdchk(cmq_pkg::A_QCALC, {8'h00, {4'h0, sg, 4'h0} + 24'h00_0010}, "queue addr");
    rdchk(8'hFC, 32'h0000_0000, "unmapped data");
    chk("unmapped resp", rr, cmq_pkg::RESP_SLVERR);
    for (t = 0; t < 12; t++)
    begin
      {m, mv, c, q, n} = {32'h0000_0001, {2{cmq_pkg::REQ_ALL_ONES}}, sg, 16'h0000, nv, 24'h01_0010};
      e = cmq_pkg::ERR_CNT;
      case (t)
        0: {m, e} = {32'h0000_0003, cmq_pkg::ERR_MODE};
        1: {mv, e} = {32'h0001_2000, cmq_pkg::ERR_MOV};
        2: {mv, e} = {32'h0000_0380, cmq_pkg::ERR_MOV};
        3: c = 32'hFFFF_FF00;
        4: c = 32'hFFFF_81FF;
        5: c = 32'hFFFD_FFFF;
        6: {q, e} = {sg, 16'h0001, cmq_pkg::ERR_QBASE};
        7: {n, e} = {nv, 24'h04_0010, cmq_pkg::ERR_NTYPE};
        8: {m, q, e} = {32'h0000_0301, 32'h0012_3458, cmq_pkg::ERR_QBASE};
        9: {c, e} = {32'h00FF_FFFF, cmq_pkg::ERR_HOSTS};
        10: {m, e} = {32'h0000_0000, cmq_pkg::ERR_NONE};
        default: {m, c, e} = {32'h0000_0002, 32'h00FF_FFFF, cmq_pkg::ERR_NONE};
      endcase
      apply('{m, mv, c, q, n});
      chk("error code", rv[7:0], e);
      rdchk(cmq_pkg::A_RPL_CNT, {(t == 11) ? 8'h00 : 8'h01, cnt[23:0]}, "kept counts");
    end
    chk("queues off", queues_on_q, 1'b0);
    pulse();
    chk("no notify", {note_wr_q, irq_q}, 2'b00);
    report_and_stop();
  end
endmodule
`default_nettype wire
